// ### core/vbrc_selfclear.sv
// Self-clearing command bits: one write of 1 gives a one-cycle pulse.
// Assumes fire inputs are already on the core clock.
`timescale 1ns/1ps
module vbrc_selfclear #(
  parameter int WIDTH = 2
) (
  // Clock and reset
  input  wire logic             mclk,
  input  wire logic             sys_rst,
  // Command bits and pulses
  input  wire logic [WIDTH-1:0] fire,
  output logic      [WIDTH-1:0] pulse
);

  // ---------------------------------------------------------------
  // One flop per command bit
  // ---------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < WIDTH; gi++) begin : g_bit
      logic pulse_reg;
      logic pulse_next;

      // Bit falls back to 0 on its own one cycle later
      always_comb begin
        pulse_next = fire[gi];
      end

      always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
          pulse_reg <= 1'b0;
        end else begin
          pulse_reg <= pulse_next;
        end
      end

      assign pulse[gi] = pulse_reg;
    end
  endgenerate

endmodule

// ### core/vbrc_top.sv
// Vector table base and application reset control registers.
// Assumes a register master on mclk that never needs a wait state,
// and a byte order strap pin that may change asynchronously.
`timescale 1ns/1ps
module vbrc_top
  import vbrc_pkg::*;
#(
  parameter logic [31:0] CODE_BASE = vbrc_pkg::CODE_SPACE_BASE,
  parameter logic [31:0] SRAM_BASE = vbrc_pkg::SRAM_SPACE_BASE
) (
  // Clock and reset
  input  wire logic                        mclk,
  input  wire logic                        sys_rst,
  // Register port
  input  wire logic [vbrc_pkg::ADDR_W-1:0] reg_addr,
  input  wire logic [vbrc_pkg::DATA_W-1:0] reg_wdata,
  input  wire logic                        reg_wr,
  input  wire logic                        reg_rd,
  output logic      [vbrc_pkg::DATA_W-1:0] reg_rdata,
  // Strap pin
  input  wire logic                        byte_order_pin,
  // Core side
  output logic      [31:0]                 vector_base,
  output logic                             table_space_select,
  output logic      [2:0]                  priority_split,
  output logic      [7:0]                  preempt_mask,
  output logic                             system_reset_request,
  output logic                             clear_active_state,
  output logic                             local_system_reset
);

  // ---------------------------------------------------------------
  // Decode
  // ---------------------------------------------------------------
  logic vto_hit;
  logic irc_hit;
  logic key_ok;
  logic irc_wr_ok;

  assign vto_hit   = (reg_addr == VTO_OFFSET);
  assign irc_hit   = (reg_addr == IRC_OFFSET);
  assign key_ok    = (reg_wdata[IRC_KEY_MSB:IRC_KEY_LSB] == IRC_WRITE_KEY);
  assign irc_wr_ok = reg_wr && irc_hit && key_ok;

  // ---------------------------------------------------------------
  // Byte order strap synchroniser
  // ---------------------------------------------------------------
  logic order_meta_reg;
  logic order_sync_reg;
  logic byte_order_reg;
  logic byte_order_next;

  // Strap read only after three flops; reset value is little-endian
  always_comb begin
    byte_order_next = order_sync_reg;
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      order_meta_reg <= 1'b0;
      order_sync_reg <= 1'b0;
      byte_order_reg <= 1'b0;
    end else begin
      order_meta_reg <= byte_order_pin;
      order_sync_reg <= order_meta_reg;
      byte_order_reg <= byte_order_next;
    end
  end

  // ---------------------------------------------------------------
  // Vector table register
  // ---------------------------------------------------------------
  logic                 space_reg;
  logic                 space_next;
  logic [VTO_OFF_W-1:0] offset_reg;
  logic [VTO_OFF_W-1:0] offset_next;
  logic [31:0]          base_reg;
  logic [31:0]          base_next;

  // Base follows the fields in the same edge, so no stale window
  always_comb begin
    space_next  = space_reg;
    offset_next = offset_reg;
    if (reg_wr && vto_hit) begin
      space_next  = reg_wdata[VTO_SPACE_BIT];
      offset_next = reg_wdata[VTO_OFF_MSB:VTO_OFF_LSB];
    end
    // Alignment is software's duty; low bits are simply not stored
    base_next = (space_next ? SRAM_BASE : CODE_BASE)
              + {3'h0, offset_next, 7'h00};
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      space_reg  <= VTO_RESET[VTO_SPACE_BIT];
      offset_reg <= VTO_RESET[VTO_OFF_MSB:VTO_OFF_LSB];
      base_reg   <= CODE_BASE;
    end else begin
      space_reg  <= space_next;
      offset_reg <= offset_next;
      base_reg   <= base_next;
    end
  end

  // ---------------------------------------------------------------
  // Reset-control register
  // ---------------------------------------------------------------
  logic [2:0] split_reg;
  logic [2:0] split_next;
  logic [7:0] mask_reg;
  logic [7:0] mask_next;
  logic       sysreq_reg;
  logic       sysreq_next;
  logic [1:0] fire;
  logic [1:0] pulse;

  // Only a keyed write touches the fields
  always_comb begin
    split_next  = split_reg;
    sysreq_next = sysreq_reg;
    if (irc_wr_ok) begin
      split_next = reg_wdata[IRC_SPLIT_MSB:IRC_SPLIT_LSB];
      if (reg_wdata[IRC_SYSREQ_BIT]) begin
        sysreq_next = 1'b1;
      end
    end
    // Pre-emption bits are the top 7-split bits of a priority byte
    mask_next = 8'hFF << ({1'b0, split_next} + 4'h1);
  end

  // Request held until the warm reset it causes clears it
  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      split_reg  <= SPLIT_RESET;
      mask_reg   <= 8'hFE;
      sysreq_reg <= IRC_RESET[IRC_SYSREQ_BIT];
    end else begin
      split_reg  <= split_next;
      mask_reg   <= mask_next;
      sysreq_reg <= sysreq_next;
    end
  end

  // Writing 0 leaves these quiet
  assign fire[1] = irc_wr_ok && reg_wdata[IRC_CLRACT_BIT];
  assign fire[0] = irc_wr_ok && reg_wdata[IRC_LRST_BIT];

  vbrc_selfclear #(
    .WIDTH (2)
  ) u_selfclear (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .fire    (fire),
    .pulse   (pulse)
  );

  // ---------------------------------------------------------------
  // Read path
  // ---------------------------------------------------------------
  logic [31:0] rdata_reg;
  logic [31:0] rdata_next;

  // Data stand only in the cycle after the strobe; unmapped reads 0
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (reg_rd && vto_hit) begin
      rdata_next[VTO_SPACE_BIT]           = space_reg;
      rdata_next[VTO_OFF_MSB:VTO_OFF_LSB] = offset_reg;
    end else if (reg_rd && irc_hit) begin
      rdata_next[IRC_KEY_MSB:IRC_KEY_LSB]     = IRC_READ_KEY;
      rdata_next[IRC_ORDER_BIT]               = byte_order_reg;
      rdata_next[IRC_SPLIT_MSB:IRC_SPLIT_LSB] = split_reg;
      rdata_next[IRC_SYSREQ_BIT]              = sysreq_reg;
      rdata_next[IRC_CLRACT_BIT]              = pulse[1];
      rdata_next[IRC_LRST_BIT]                = pulse[0];
    end
  end

  always_ff @(posedge mclk or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_reg <= 32'h0000_0000;
    end else begin
      rdata_reg <= rdata_next;
    end
  end

  // ---------------------------------------------------------------
  // Outputs
  // ---------------------------------------------------------------
  assign reg_rdata            = rdata_reg;
  assign vector_base          = base_reg;
  assign table_space_select   = space_reg;
  assign priority_split       = split_reg;
  assign preempt_mask         = mask_reg;
  assign system_reset_request = sysreq_reg;
  assign clear_active_state   = pulse[1];
  assign local_system_reset   = pulse[0];

  // ---------------------------------------------------------------
  // Assertions
  // ---------------------------------------------------------------
  property p_space_select;
    @(posedge mclk) disable iff (sys_rst)
    (reg_wr && vto_hit) |=> (vector_base - {3'h0, offset_reg, 7'h00})
      == ($past(reg_wdata[VTO_SPACE_BIT]) ? SRAM_BASE : CODE_BASE);
  endproperty
  a_space_select: assert property (p_space_select)
    else $error("vector base not in the selected space");

  property p_offset_add;
    @(posedge mclk) disable iff (sys_rst)
    (reg_wr && vto_hit && !reg_wdata[VTO_SPACE_BIT]) |=>
      vector_base == CODE_BASE + {3'h0, $past(reg_wdata[VTO_OFF_MSB:VTO_OFF_LSB]), 7'h00}
      ##1 ($past(reg_wr && vto_hit) || $stable(vector_base));
  endproperty
  a_offset_add: assert property (p_offset_add)
    else $error("vector base offset wrong");

  property p_bad_key;
    @(posedge mclk) disable iff (sys_rst)
    (reg_wr && irc_hit && !key_ok) |=>
      $stable(priority_split) && !clear_active_state && !local_system_reset;
  endproperty
  a_bad_key: assert property (p_bad_key)
    else $error("unkeyed write changed reset control");

  property p_read_key;
    @(posedge mclk) disable iff (sys_rst)
    (reg_rd && irc_hit) |=> reg_rdata[IRC_KEY_MSB:IRC_KEY_LSB] == IRC_READ_KEY;
  endproperty
  a_read_key: assert property (p_read_key)
    else $error("key readback pattern wrong");

  property p_byte_order;
    @(posedge mclk) disable iff (sys_rst)
    (reg_rd && irc_hit) |=> reg_rdata[IRC_ORDER_BIT] == $past(order_sync_reg, 2);
  endproperty
  a_byte_order: assert property (p_byte_order)
    else $error("byte order bit wrong");

  property p_split;
    @(posedge mclk) disable iff (sys_rst)
    irc_wr_ok |=> priority_split == $past(reg_wdata[IRC_SPLIT_MSB:IRC_SPLIT_LSB])
      && preempt_mask[7] == (priority_split != 3'h7) && !preempt_mask[0];
  endproperty
  a_split: assert property (p_split)
    else $error("priority split or mask wrong");

  property p_sysreq;
    @(posedge mclk) disable iff (sys_rst)
    $rose(system_reset_request) |-> $past(irc_wr_ok && reg_wdata[IRC_SYSREQ_BIT])
      ##1 system_reset_request [*3];
  endproperty
  a_sysreq: assert property (p_sysreq)
    else $error("reset request not held");

  property p_clear_active;
    @(posedge mclk) disable iff (sys_rst)
    (irc_wr_ok && reg_wdata[IRC_CLRACT_BIT]) |=> clear_active_state
      ##1 (!clear_active_state || $past(irc_wr_ok && reg_wdata[IRC_CLRACT_BIT]));
  endproperty
  a_clear_active: assert property (p_clear_active)
    else $error("clear active pulse wrong");

  property p_local_reset;
    @(posedge mclk) disable iff (sys_rst)
    local_system_reset |-> $past(irc_wr_ok && reg_wdata[IRC_LRST_BIT]);
  endproperty
  a_local_reset: assert property (p_local_reset)
    else $error("local reset without keyed write of 1");

  property p_reserved;
    @(posedge mclk) disable iff (sys_rst)
    reg_rd |=> reg_rdata[6:3] == 4'h0
      && ($past(irc_hit) ? (reg_rdata[14:11] == 4'h0 && !reg_rdata[7])
                         : (reg_rdata[31:30] == 2'h0 && reg_rdata[2:0] == 3'h0));
  endproperty
  a_reserved: assert property (p_reserved)
    else $error("reserved bits not zero");

  c_keyed_write: cover property (@(posedge mclk) disable iff (sys_rst) irc_wr_ok);
  c_bad_key: cover property (@(posedge mclk) disable iff (sys_rst)
    reg_wr && irc_hit && !key_ok);
  c_sram_table: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(table_space_select));
  c_reset_req: cover property (@(posedge mclk) disable iff (sys_rst)
    $rose(system_reset_request));

endmodule

// ### pkg/vbrc_pkg.sv
// Constants for the vector base and reset control block.
// Assumes a single 10 MHz core clock and the simple register port.
//
// What this block does
// - Bit 29 of the vector table register picks code space (0) or SRAM space (1).
// - Bits 28 to 7 hold an offset that is added to the chosen space start.
// - A reset-control write counts only when bits 31 to 16 carry 0x5FA.
// - A reset-control read returns 0xFA05 in its upper sixteen bits.
// - Bit 15 of the reset-control register reports byte order, 1 big-endian.
// - Bits 10 to 8 split each priority byte into pre-emption and sub-priority.
// - Writing 1 to bit 2 raises the reset request until the warm reset clears it.
// - Writing 1 to bit 1 clears all active exception state, then reads 0 again.
// - Writing 1 to bit 0 resets the system but debug, then clears; 0 does nothing.
package vbrc_pkg;

  // ---------------------------------------------------------------
  // Register port
  // ---------------------------------------------------------------
  localparam int          ADDR_W      = 8;
  localparam int          DATA_W      = 32;
  localparam logic [7:0]  VTO_OFFSET  = 8'h08;
  localparam logic [7:0]  IRC_OFFSET  = 8'h0C;

  // ---------------------------------------------------------------
  // Vector table register fields
  // ---------------------------------------------------------------
  localparam int          VTO_SPACE_BIT = 29;
  localparam int          VTO_OFF_MSB   = 28;
  localparam int          VTO_OFF_LSB   = 7;
  localparam int          VTO_OFF_W     = VTO_OFF_MSB - VTO_OFF_LSB + 1;
  localparam logic [31:0] VTO_RESET     = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Reset-control register fields
  // ---------------------------------------------------------------
  localparam int          IRC_KEY_MSB    = 31;
  localparam int          IRC_KEY_LSB    = 16;
  localparam logic [15:0] IRC_WRITE_KEY  = 16'h05FA;
  localparam logic [15:0] IRC_READ_KEY   = 16'hFA05;
  localparam int          IRC_ORDER_BIT  = 15;
  localparam int          IRC_SPLIT_MSB  = 10;
  localparam int          IRC_SPLIT_LSB  = 8;
  localparam int          IRC_SYSREQ_BIT = 2;
  localparam int          IRC_CLRACT_BIT = 1;
  localparam int          IRC_LRST_BIT   = 0;
  localparam logic [31:0] IRC_RESET      = 32'h0000_0000;
  localparam logic [2:0]  SPLIT_RESET    = 3'h0;

  // ---------------------------------------------------------------
  // Address space starts
  // ---------------------------------------------------------------
  localparam logic [31:0] CODE_SPACE_BASE = 32'h0000_0000;
  localparam logic [31:0] SRAM_SPACE_BASE = 32'h2000_0000;

endpackage

// ### testbench/vbrc_top_tb_top.sv
// Self-checking bench for the vector base and reset control block.
// Assumes the register port answers reads one cycle after the strobe
// and that register writes show on the core-side outputs one cycle later.
`timescale 1ns/1ps
module vbrc_top_tb_top;
  import vbrc_pkg::*;

  // ---------------------------------------------------------------
  // Signals and counters
  // ---------------------------------------------------------------
  logic        mclk;
  logic        sys_rst;
  logic [7:0]  reg_addr;
  logic [31:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [31:0] reg_rdata;
  logic        byte_order_pin;
  logic [31:0] vector_base;
  logic        table_space_select;
  logic [2:0]  priority_split;
  logic [7:0]  preempt_mask;
  logic        system_reset_request;
  logic        clear_active_state;
  logic        local_system_reset;
  int          fails;
  int          n_compared;
  logic [31:0] vt_cases [4] = '{32'h2000_0080, 32'hFFFF_FFFF, 32'h0000_1000, 32'h1FFF_FF80};
  logic [15:0] bad_keys [3] = '{16'h0000, 16'hFA05, 16'h05FB};
  logic [31:0] exp_base;
  logic [7:0]  exp_mask;

  vbrc_top i_dut (
    .mclk                 (mclk),
    .sys_rst              (sys_rst),
    .reg_addr             (reg_addr),
    .reg_wdata            (reg_wdata),
    .reg_wr               (reg_wr),
    .reg_rd               (reg_rd),
    .reg_rdata            (reg_rdata),
    .byte_order_pin       (byte_order_pin),
    .vector_base          (vector_base),
    .table_space_select   (table_space_select),
    .priority_split       (priority_split),
    .preempt_mask         (preempt_mask),
    .system_reset_request (system_reset_request),
    .clear_active_state   (clear_active_state),
    .local_system_reset   (local_system_reset)
  );

  // ---------------------------------------------------------------
  // Clock, verdict and watchdog
  // ---------------------------------------------------------------
  // 100 ns period
  initial begin
    mclk = 1'b0;
    forever #50 mclk = ~mclk;
  end

  task automatic give_verdict();
    $display("compared %0d, mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // Whole run is about 120 cycles, so 2000 leaves ample margin
  initial begin
    #(2000 * 100);
    fails++;
    give_verdict();
  end

  // ---------------------------------------------------------------
  // Access tasks
  // ---------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] expd);
    n_compared++;
    if (seen !== expd) begin
      fails++;
      $display("unexpected at %0t: seen %h expected %h", $time, seen, expd);
    end
  endtask

  // Returns just after the taking edge, when register outputs have landed
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge mclk);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge mclk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] expd);
    @(posedge mclk);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    check(reg_rdata, expd);
  endtask

  // Checks a one-cycle pulse: high now, low one cycle later
  task automatic pulse_chk(input bit pick_clear);
    check({31'h0, (pick_clear ? clear_active_state : local_system_reset)}, 32'h1);
    @(posedge mclk);
    #1;
    check({31'h0, (pick_clear ? clear_active_state : local_system_reset)}, 32'h0);
  endtask

  // ---------------------------------------------------------------
  // Test sequence
  // ---------------------------------------------------------------
  initial begin
    sys_rst = 1'b1; reg_addr = 8'h00; reg_wdata = 32'h0; reg_wr = 1'b0;
    reg_rd = 1'b0; byte_order_pin = 1'b0; fails = 0; n_compared = 0;
    repeat (5) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    // Reset state and readback
    check(vector_base, CODE_SPACE_BASE);
    check({24'h0, preempt_mask}, 32'h0000_00FE);
    rd_chk(VTO_OFFSET, VTO_RESET);
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h0000});
    rd_chk(8'h10, 32'h0);
    // Vector table: both spaces, all-ones to probe reserved bits
    foreach (vt_cases[i]) begin
      wr(VTO_OFFSET, vt_cases[i]);
      exp_base = (vt_cases[i][29] ? SRAM_SPACE_BASE : CODE_SPACE_BASE)
               + (vt_cases[i] & 32'h1FFF_FF80);
      check(vector_base, exp_base);
      check({31'h0, table_space_select}, {31'h0, vt_cases[i][29]});
      rd_chk(VTO_OFFSET, vt_cases[i] & 32'h3FFF_FF80);
    end
    // Unmapped write must not land anywhere
    wr(8'h10, 32'h0000_0000);
    rd_chk(VTO_OFFSET, 32'h1FFF_FF80);
    // Every grouping code, with its pre-emption mask
    for (int s = 0; s < 8; s++) begin
      wr(IRC_OFFSET, {IRC_WRITE_KEY, 5'h00, 3'(s), 8'h00});
      exp_mask = 8'hFF << (s + 1);
      check({29'h0, priority_split}, 32'(s));
      check({24'h0, preempt_mask}, {24'h0, exp_mask});
      rd_chk(IRC_OFFSET, {IRC_READ_KEY, 5'h00, 3'(s), 8'h00});
    end
    // Wrong keys: nothing may change and no command may fire
    foreach (bad_keys[i]) begin
      wr(IRC_OFFSET, {bad_keys[i], 16'h0307});
      check({29'h0, priority_split}, 32'h7);
      check({29'h0, system_reset_request, clear_active_state, local_system_reset}, 0);
    end
    // Self-clearing commands
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'h0302});
    check({31'h0, local_system_reset}, 32'h0);
    pulse_chk(1'b1);
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h0300});
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'h0301});
    check({31'h0, clear_active_state}, 32'h0);
    pulse_chk(1'b0);
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'h0300});
    check({31'h0, local_system_reset}, 32'h0);
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h0300});
    // Byte order follows the strap; writes to it are ignored
    @(posedge mclk);
    byte_order_pin <= 1'b1;
    repeat (4) @(posedge mclk);
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h8300});
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'h0300});
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h8300});
    @(posedge mclk);
    byte_order_pin <= 1'b0;
    repeat (4) @(posedge mclk);
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'hFFF8});
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h0700});
    // Reset request stays up until the warm reset
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'h0704});
    check({31'h0, system_reset_request}, 32'h1);
    wr(IRC_OFFSET, {IRC_WRITE_KEY, 16'h0700});
    check({31'h0, system_reset_request}, 32'h1);
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h0704});
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    #1;
    check({31'h0, system_reset_request}, 32'h0);
    check({29'h0, priority_split}, 32'h0);
    check(vector_base, CODE_SPACE_BASE);
    repeat (3) @(posedge mclk);
    rd_chk(IRC_OFFSET, {IRC_READ_KEY, 16'h0000});
    rd_chk(VTO_OFFSET, VTO_RESET);
    give_verdict();
  end

endmodule
